/* hdl/acgc_pkg.sv */
// Purpose: Constants and types for the converter channel and GPIO control block.
// Assumes: 100 MHz system clock, 12 ns conversion clock, APB register access.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package acgc_pkg;
  localparam int NUM_CH = 8;
  localparam int RES_W = 12;
  localparam int AVG_W = 16;
  localparam int SYS_CLK_NS = 10;
  localparam int CONV_CLK_NS = 12;
  localparam int NS_PER_MS = 1000000;
  localparam int T_PU_MS = 5;
  localparam int T_RST_MS = 5;
  localparam int T_ACQ_NS = 400;
  localparam int T_CONV_NS = 600;
  // Longest times round down, least times round up
  localparam int PU_CYCLES = T_PU_MS * NS_PER_MS / SYS_CLK_NS;
  localparam int RST_CYCLES = T_RST_MS * NS_PER_MS / SYS_CLK_NS;
  localparam int ACQ_CYCLES = (T_ACQ_NS + CONV_CLK_NS - 1) / CONV_CLK_NS;
  localparam int CONV_CYCLES = (T_CONV_NS + CONV_CLK_NS - 1) / CONV_CLK_NS;
  localparam logic [3:0] AVG_LAST = 4'hF;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAN = 8'h04;
  localparam logic [7:0] ADDR_PIN_MODE = 8'h08;
  localparam logic [7:0] ADDR_DIR = 8'h0C;
  localparam logic [7:0] ADDR_OUT_VAL = 8'h10;
  localparam logic [7:0] ADDR_DRV_TYPE = 8'h14;
  localparam logic [7:0] ADDR_IN_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1C;
  localparam logic [7:0] ADDR_AVG = 8'h20;
  localparam logic [7:0] ADDR_HI_THR = 8'h24;
  localparam logic [7:0] ADDR_LO_THR = 8'h28;
  localparam logic [7:0] ADDR_EVENT = 8'h2C;
  // Control and result field positions
  localparam int CTRL_RST_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_AVG_BIT = 3;
  localparam int CTRL_READY_BIT = 8;
  localparam int RES_CHAN_LSB = 16;
  // Values after reset
  localparam logic [7:0] PIN_MODE_RST = 8'h00;
  localparam logic [7:0] CFG8_RST = 8'h00;
  localparam logic [11:0] HI_THR_RST = 12'hFFF;
  localparam logic [11:0] LO_THR_RST = 12'h000;
  typedef logic [18:0] acgc_rcnt_t;
  typedef logic [5:0] acgc_ccnt_t;
  typedef struct packed {
    logic [7:0] pin_mode;
    logic [7:0] dir;
    logic [7:0] out_val;
    logic [7:0] drv;
  } acgc_gpio_cfg_t;
  typedef struct packed {
    logic [2:0] chan;
    logic [11:0] code;
  } acgc_sample_t;
  typedef enum logic [1:0] {CV_IDLE, CV_ACQ, CV_CONV} acgc_cv_state_t;
endpackage

/* hdl/acgc_top.sv */
// Purpose: Channel pin-mode, GPIO, conversion sequencing, averaging and alert logic.
// Assumes: APB master on CLK_SYS_I; analog core code valid at end of conversion.
// Notes: Conversion timing runs on CLK_CONV_I; requests and results cross by toggle.
`timescale 1ns/10ps
module acgc_top #(
  parameter int unsigned PU_DELAY_CYCLES = acgc_pkg::PU_CYCLES,
  parameter int unsigned RST_DELAY_CYCLES = acgc_pkg::RST_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic CLK_CONV_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] GPIO_IN_I,
  output logic [7:0] GPIO_OUT_O,
  output logic [7:0] GPIO_OE_O,
  output logic [7:0] ANALOG_EN_O,
  input wire logic [11:0] ADC_CODE_I,
  output logic [2:0] MUX_SEL_O,
  output logic SAMPLING_SWITCH_O,
  output logic ALERT_O
);
  acgc_pkg::acgc_gpio_cfg_t cfg_q;
  acgc_pkg::acgc_sample_t samp_q;
  acgc_pkg::acgc_cv_state_t cv_state_q;
  acgc_pkg::acgc_rcnt_t rst_cnt_q;
  acgc_pkg::acgc_ccnt_t cv_cnt_q;
  logic busy_q, soft_rst_q, pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_data;
  logic rd_hit, wr_en, soft_rst_wr, rd_data_ready_ok;
  logic auto_q, avg_q, man_go_q, pend_q;
  logic [2:0] chan_sel_q, req_chan_q, nxt_chan;
  logic issue;
  logic [3:0] nxt_an;
  logic [11:0] hi_thr_q, lo_thr_q, res_code_q, cmp_code;
  logic [2:0] res_chan_q;
  logic [15:0] acc_q, avg_res_q, sum;
  logic [3:0] avg_cnt_q;
  logic [7:0] evt_q, evt_set, in_lvl_q, gpio_s1, gpio_s2;
  logic cmp_valid;
  logic req_tgl_q, done_s1, done_s2, done_s3, done_evt;
  logic req_s1, req_s2, req_seen_q, done_tgl_q, new_req;
  logic [11:0] code_s1, code_s2;
  logic [7:0] out_en;

  // First analog channel after cur, bit 3 set when none
  function automatic logic [3:0] next_analog(input logic [2:0] cur, input logic [7:0] pm);
    logic [3:0] r;
    logic [2:0] c;
    r = 4'h8;
    for (int i = acgc_pkg::NUM_CH; i >= 1; i--) begin
      c = cur + 3'(i);
      if (!pm[c]) begin
        r = {1'b0, c};
      end
    end
    return r;
  endfunction

  // APB access phase strobes; write lands on the edge that sees PREADY
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_q;
  assign soft_rst_wr = wr_en && !busy_q && (PADDR_I == acgc_pkg::ADDR_CTRL)
                       && PWDATA_I[acgc_pkg::CTRL_RST_BIT];

  // Init and reset timer; power-up and soft reset share it
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy_q <= 1'b1;
      rst_cnt_q <= acgc_pkg::acgc_rcnt_t'(PU_DELAY_CYCLES);
      soft_rst_q <= 1'b0;
    end else if (soft_rst_wr) begin
      busy_q <= 1'b1;
      rst_cnt_q <= acgc_pkg::acgc_rcnt_t'(RST_DELAY_CYCLES);
      soft_rst_q <= 1'b1;
    end else if (busy_q) begin
      rst_cnt_q <= rst_cnt_q - 19'h00001;
      if (rst_cnt_q <= 19'h00001) begin
        busy_q <= 1'b0;
        soft_rst_q <= 1'b0;
      end
    end
  end

  // Configuration registers, held at defaults through any reset
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_q.pin_mode <= acgc_pkg::PIN_MODE_RST;
      cfg_q.dir <= acgc_pkg::CFG8_RST;
      cfg_q.out_val <= acgc_pkg::CFG8_RST;
      cfg_q.drv <= acgc_pkg::CFG8_RST;
      auto_q <= 1'b0;
      avg_q <= 1'b0;
      chan_sel_q <= 3'h0;
      hi_thr_q <= acgc_pkg::HI_THR_RST;
      lo_thr_q <= acgc_pkg::LO_THR_RST;
    end else if (busy_q) begin
      cfg_q.pin_mode <= acgc_pkg::PIN_MODE_RST;
      cfg_q.dir <= acgc_pkg::CFG8_RST;
      cfg_q.out_val <= acgc_pkg::CFG8_RST;
      cfg_q.drv <= acgc_pkg::CFG8_RST;
      auto_q <= 1'b0;
      avg_q <= 1'b0;
      chan_sel_q <= 3'h0;
      hi_thr_q <= acgc_pkg::HI_THR_RST;
      lo_thr_q <= acgc_pkg::LO_THR_RST;
    end else if (wr_en) begin
      case (PADDR_I)
        acgc_pkg::ADDR_CTRL: begin
          auto_q <= PWDATA_I[acgc_pkg::CTRL_AUTO_BIT];
          avg_q <= PWDATA_I[acgc_pkg::CTRL_AVG_BIT];
        end
        acgc_pkg::ADDR_CHAN: chan_sel_q <= PWDATA_I[2:0];
        acgc_pkg::ADDR_PIN_MODE: cfg_q.pin_mode <= PWDATA_I[7:0];
        acgc_pkg::ADDR_DIR: cfg_q.dir <= PWDATA_I[7:0];
        acgc_pkg::ADDR_OUT_VAL: cfg_q.out_val <= PWDATA_I[7:0];
        acgc_pkg::ADDR_DRV_TYPE: cfg_q.drv <= PWDATA_I[7:0];
        acgc_pkg::ADDR_HI_THR: hi_thr_q <= PWDATA_I[11:0];
        acgc_pkg::ADDR_LO_THR: lo_thr_q <= PWDATA_I[11:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (PADDR_I)
      acgc_pkg::ADDR_CTRL: begin
        rd_data[acgc_pkg::CTRL_RST_BIT] = soft_rst_q;
        // Stays set across a whole averaging run so polling sees one busy span
        rd_data[acgc_pkg::CTRL_START_BIT] = pend_q | man_go_q | (avg_q && avg_cnt_q != 4'h0);
        rd_data[acgc_pkg::CTRL_AUTO_BIT] = auto_q;
        rd_data[acgc_pkg::CTRL_AVG_BIT] = avg_q;
        rd_data[acgc_pkg::CTRL_READY_BIT] = !busy_q;
      end
      acgc_pkg::ADDR_CHAN: rd_data[2:0] = chan_sel_q;
      acgc_pkg::ADDR_PIN_MODE: rd_data[7:0] = cfg_q.pin_mode;
      acgc_pkg::ADDR_DIR: rd_data[7:0] = cfg_q.dir;
      acgc_pkg::ADDR_OUT_VAL: rd_data[7:0] = cfg_q.out_val;
      acgc_pkg::ADDR_DRV_TYPE: rd_data[7:0] = cfg_q.drv;
      acgc_pkg::ADDR_IN_LEVEL: rd_data[7:0] = in_lvl_q;
      acgc_pkg::ADDR_RESULT: begin
        rd_data[11:0] = res_code_q;
        rd_data[acgc_pkg::RES_CHAN_LSB +: 3] = res_chan_q;
      end
      acgc_pkg::ADDR_AVG: rd_data[15:0] = avg_res_q;
      acgc_pkg::ADDR_HI_THR: rd_data[11:0] = hi_thr_q;
      acgc_pkg::ADDR_LO_THR: rd_data[11:0] = lo_thr_q;
      acgc_pkg::ADDR_EVENT: rd_data[7:0] = evt_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait state gives registered read data and response
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (PSEL_I && PENABLE_I && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !rd_hit;
      prdata_q <= PWRITE_I ? 32'h00000000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

  // Pin inputs pass three flops before readback
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gpio_s1 <= 8'h00;
      gpio_s2 <= 8'h00;
      in_lvl_q <= 8'h00;
    end else begin
      gpio_s1 <= GPIO_IN_I;
      gpio_s2 <= gpio_s1;
      in_lvl_q <= gpio_s2 & cfg_q.pin_mode & ~cfg_q.dir;
    end
  end

  // Pin drive; analog channels never drive, whatever dir and drv say
  assign out_en = cfg_q.pin_mode & cfg_q.dir;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      GPIO_OE_O <= 8'h00;
      GPIO_OUT_O <= 8'h00;
      ANALOG_EN_O <= 8'hFF;
    end else begin
      // Open-drain pulls low for a 0 and floats for a 1
      GPIO_OE_O <= out_en & (cfg_q.drv | ~cfg_q.out_val);
      GPIO_OUT_O <= out_en & cfg_q.drv & cfg_q.out_val;
      ANALOG_EN_O <= ~cfg_q.pin_mode;
    end
  end

  // Pick the next conversion: averaging run, manual start, then scan
  assign nxt_an = next_analog(req_chan_q, cfg_q.pin_mode);
  always_comb begin
    issue = 1'b0;
    nxt_chan = req_chan_q;
    if (!busy_q && !pend_q) begin
      if (avg_q && avg_cnt_q != 4'h0) begin
        issue = 1'b1;
      end else if (man_go_q) begin
        issue = 1'b1;
        nxt_chan = chan_sel_q;
      end else if (auto_q && !nxt_an[3]) begin
        issue = 1'b1;
        nxt_chan = nxt_an[2:0];
      end
    end
  end

  // Request side of the crossing; channel is held until the result returns
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      man_go_q <= 1'b0;
      pend_q <= 1'b0;
      req_tgl_q <= 1'b0;
      req_chan_q <= 3'h0;
    end else if (busy_q) begin
      man_go_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (issue) begin
        req_tgl_q <= ~req_tgl_q;
        req_chan_q <= nxt_chan;
        pend_q <= 1'b1;
      end else if (done_evt) begin
        pend_q <= 1'b0;
      end
      if (wr_en && PADDR_I == acgc_pkg::ADDR_CTRL && PWDATA_I[acgc_pkg::CTRL_START_BIT]) begin
        man_go_q <= 1'b1;
      end else if (issue && !(avg_q && avg_cnt_q != 4'h0)) begin
        man_go_q <= 1'b0;
      end
    end
  end

  // Result toggle arrives through two flops, third detects the edge
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      done_s1 <= done_tgl_q;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end
  // A stray result after a reset is dropped since nothing is pending
  assign done_evt = (done_s2 ^ done_s3) && pend_q;

  // Averaging sums sixteen 12-bit codes into a 16-bit result
  assign sum = acc_q + {4'h0, samp_q.code};
  assign cmp_valid = done_evt && (!avg_q || avg_cnt_q == acgc_pkg::AVG_LAST);
  assign cmp_code = avg_q ? sum[15:4] : samp_q.code;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      res_code_q <= 12'h000;
      res_chan_q <= 3'h0;
      acc_q <= 16'h0000;
      avg_cnt_q <= 4'h0;
      avg_res_q <= 16'h0000;
    end else if (busy_q || !avg_q) begin
      acc_q <= 16'h0000;
      avg_cnt_q <= 4'h0;
      if (busy_q) begin
        res_code_q <= 12'h000;
        res_chan_q <= 3'h0;
        avg_res_q <= 16'h0000;
      end else if (done_evt) begin
        res_code_q <= samp_q.code;
        res_chan_q <= samp_q.chan;
      end
    end else if (done_evt) begin
      res_code_q <= samp_q.code;
      res_chan_q <= samp_q.chan;
      avg_cnt_q <= avg_cnt_q + 4'h1;
      if (avg_cnt_q == acgc_pkg::AVG_LAST) begin
        avg_res_q <= sum;
        acc_q <= 16'h0000;
      end else begin
        acc_q <= sum;
      end
    end
  end

  // Window comparator; a new event wins over a same-cycle clear
  always_comb begin
    evt_set = 8'h00;
    if (cmp_valid && (cmp_code > hi_thr_q || cmp_code < lo_thr_q)) begin
      evt_set[samp_q.chan] = 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      evt_q <= 8'h00;
      ALERT_O <= 1'b0;
    end else if (busy_q) begin
      evt_q <= 8'h00;
      ALERT_O <= 1'b0;
    end else begin
      if (wr_en && PADDR_I == acgc_pkg::ADDR_EVENT) begin
        evt_q <= (evt_q & ~PWDATA_I[7:0]) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
      ALERT_O <= |evt_q;
    end
  end

  // Conversion clock domain: request sync and analog code sync
  always_ff @(posedge CLK_CONV_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      code_s1 <= 12'h000;
      code_s2 <= 12'h000;
    end else begin
      req_s1 <= req_tgl_q;
      req_s2 <= req_s1;
      code_s1 <= ADC_CODE_I;
      code_s2 <= code_s1;
    end
  end
  assign new_req = req_s2 ^ req_seen_q;

  // Acquire with switch closed, then convert with it open
  always_ff @(posedge CLK_CONV_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cv_state_q <= acgc_pkg::CV_IDLE;
      cv_cnt_q <= 6'h00;
      req_seen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      MUX_SEL_O <= 3'h0;
      SAMPLING_SWITCH_O <= 1'b0;
      samp_q <= '0;
    end else begin
      case (cv_state_q)
        acgc_pkg::CV_IDLE: begin
          if (new_req) begin
            req_seen_q <= req_s2;
            MUX_SEL_O <= req_chan_q;
            SAMPLING_SWITCH_O <= 1'b1;
            cv_cnt_q <= acgc_pkg::acgc_ccnt_t'(acgc_pkg::ACQ_CYCLES - 1);
            cv_state_q <= acgc_pkg::CV_ACQ;
          end
        end
        acgc_pkg::CV_ACQ: begin
          cv_cnt_q <= cv_cnt_q - 6'h01;
          if (cv_cnt_q == 6'h00) begin
            SAMPLING_SWITCH_O <= 1'b0;
            cv_cnt_q <= acgc_pkg::acgc_ccnt_t'(acgc_pkg::CONV_CYCLES - 1);
            cv_state_q <= acgc_pkg::CV_CONV;
          end
        end
        acgc_pkg::CV_CONV: begin
          cv_cnt_q <= cv_cnt_q - 6'h01;
          if (cv_cnt_q == 6'h00) begin
            samp_q.code <= code_s2;
            samp_q.chan <= MUX_SEL_O;
            done_tgl_q <= ~done_tgl_q;
            cv_state_q <= acgc_pkg::CV_IDLE;
          end
        end
        default: cv_state_q <= acgc_pkg::CV_IDLE;
      endcase
    end
  end

  // Checks
  sequence s_acq_hold;
    SAMPLING_SWITCH_O [*8];
  endsequence
  sequence s_conv_open;
    !SAMPLING_SWITCH_O [*8];
  endsequence

  a_switch_acq: assert property (@(posedge CLK_CONV_I) disable iff (!RST_B_I)
    $rose(SAMPLING_SWITCH_O) |-> s_acq_hold)
    else $error("Sampling switch opened early");
  a_switch_conv: assert property (@(posedge CLK_CONV_I) disable iff (!RST_B_I)
    $fell(SAMPLING_SWITCH_O) |-> cv_state_q == acgc_pkg::CV_CONV ##0 s_conv_open)
    else $error("Sampling switch closed during conversion");
  a_rst_self_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $fell(busy_q) |-> !soft_rst_q && rd_data_ready_ok)
    else $error("Reset bit still set after reset");
  a_rst_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    soft_rst_wr |=> busy_q && soft_rst_q && rst_cnt_q == acgc_pkg::acgc_rcnt_t'(RST_DELAY_CYCLES))
    else $error("Soft reset did not start timer");
  a_analog_default: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    busy_q |=> cfg_q.pin_mode == 8'h00 ##1 ANALOG_EN_O == 8'hFF)
    else $error("Channels not analog during reset");
  a_od_drive: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cfg_q.pin_mode[0] && cfg_q.dir[0] && !cfg_q.drv[0] |=> !GPIO_OUT_O[0]
      && GPIO_OE_O[0] == !$past(cfg_q.out_val[0]))
    else $error("Open-drain output drove high");
  a_pp_level: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    cfg_q.pin_mode[1] && cfg_q.dir[1] && cfg_q.drv[1] |=> GPIO_OE_O[1]
      && GPIO_OUT_O[1] == $past(cfg_q.out_val[1]))
    else $error("Push-pull output level wrong");
  a_analog_float: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    !cfg_q.pin_mode[2] |=> !GPIO_OE_O[2] && !GPIO_OUT_O[2])
    else $error("Analog channel drove its pin");
  a_alert_raise: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    evt_set != 8'h00 && !busy_q |=> ##1 ALERT_O)
    else $error("Threshold event did not alert");
  a_auto_issue: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    auto_q && !busy_q && !pend_q && !nxt_an[3] |=> pend_q)
    else $error("Autonomous mode did not start conversion");

  assign rd_data_ready_ok = rd_data[acgc_pkg::CTRL_READY_BIT] || PADDR_I != acgc_pkg::ADDR_CTRL;
endmodule

/* tb/acgc_analog_model.sv */
// Purpose: Converter core and pin model at the far side of the block.
// Assumes: Code is only trusted once the sampling switch opens.
// Notes: Pins not driven by the block take the outside level.
`timescale 1ns/10ps
module acgc_analog_model (
  input wire logic clk_conv_i,
  input wire logic switch_i,
  input wire logic [2:0] mux_i,
  input wire logic [11:0] base_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [11:0] code_o,
  output logic [7:0] pin_o
);
  // Driven pins follow the block, released ones the outside pull
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
  // Code churns while tracking so a sample taken too early shows up
  always_ff @(posedge clk_conv_i) begin
    if (switch_i) begin
      code_o <= ~code_o;
    end else begin
      code_o <= base_i + 12'(mux_i);
    end
  end
endmodule

/* tb/adc_channel_gpio_control_tb.sv */
// Purpose: Self-checking bench for channel, GPIO and conversion control.
// Assumes: Power-up and reset delays shortened to 20 cycles.
// Notes: Random values from a 16-bit shift register, fixed start.
`timescale 1ns/10ps
module adc_channel_gpio_control_tb;
  logic clk_sys, clk_conv, rst_b, psel, penable, pwrite, pready, pslverr, sw, alert, err, prev;
  logic [7:0] paddr, gin, gout, goe, aen, ext, pm, dir, ov, drv;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] code, base, expc;
  logic [2:0] mux, ch;
  logic [15:0] lfsr, r;
  int errors = 0, num_checks = 0, cycles = 0, i, k;

  // Block under test with short delays
  acgc_top #(.PU_DELAY_CYCLES(20), .RST_DELAY_CYCLES(20)) dut_u (.CLK_SYS_I(clk_sys),
    .RST_B_I(rst_b), .CLK_CONV_I(clk_conv), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .GPIO_IN_I(gin), .GPIO_OUT_O(gout),
    .GPIO_OE_O(goe), .ANALOG_EN_O(aen), .ADC_CODE_I(code), .MUX_SEL_O(mux),
    .SAMPLING_SWITCH_O(sw), .ALERT_O(alert));
  // Converter core and pins
  acgc_analog_model model_u (.clk_conv_i(clk_conv), .switch_i(sw), .mux_i(mux),
    .base_i(base), .out_i(gout), .oe_i(goe), .ext_i(ext), .code_o(code), .pin_o(gin));

  // Clocks of unrelated phase
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_conv = 1'b0;
    #3;
    forever #6 clk_conv = ~clk_conv;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Expected output enable, output value and analog enable
  function automatic logic [23:0] pins(input logic [7:0] m, d, v, t);
    return {m & d & (t | ~v), m & d & t & v, ~m};
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  // One transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(pready));
  endtask
  // Read until a bit settles; bounded so a stuck bit fails
  task automatic poll(input logic [7:0] a, input int b, input logic v, input int lim);
    int t;
    t = 0;
    do begin
      apb(1'b0, a, 32'h0);
      t++;
    end while (rd[b] !== v && t < lim);
    chk("poll", 32'(v), 32'(rd[b]));
  endtask
  task automatic conv(input logic [31:0] c);
    apb(1'b1, acgc_pkg::ADDR_CTRL, c);
    poll(acgc_pkg::ADDR_CTRL, acgc_pkg::CTRL_START_BIT, 1'b0, 600);
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    lfsr = 16'h7E11;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 8'hA5;
    base = 12'h123;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("analog_en", 32'hFF, 32'(aen));
    apb(1'b0, acgc_pkg::ADDR_CTRL, 32'h0);
    chk("ready_early", 32'h0, 32'(rd[acgc_pkg::CTRL_READY_BIT]));
    poll(acgc_pkg::ADDR_CTRL, acgc_pkg::CTRL_READY_BIT, 1'b1, 8);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    $display("test power_up done");
    // Corner settings first, then random ones
    for (i = 0; i < 12; i++) begin
      r = rnd();
      pm = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
      dir = (i < 2) ? 8'hFF : r[15:8];
      r = rnd();
      ov = r[7:0];
      drv = (i == 0) ? 8'h33 : r[15:8];
      r = rnd();
      ext <= r[7:0];
      apb(1'b1, acgc_pkg::ADDR_PIN_MODE, 32'(pm));
      apb(1'b1, acgc_pkg::ADDR_DIR, 32'(dir));
      apb(1'b1, acgc_pkg::ADDR_OUT_VAL, 32'(ov));
      apb(1'b1, acgc_pkg::ADDR_DRV_TYPE, 32'(drv));
      apb(1'b0, acgc_pkg::ADDR_IN_LEVEL, 32'h0);
      chk("input_level", 32'(pm & ~dir & ext), rd);
      chk("pins", 32'(pins(pm, dir, ov, drv)), 32'({goe, gout, aen}));
    end
    $display("test gpio done");
    apb(1'b1, acgc_pkg::ADDR_PIN_MODE, 32'h0);
    for (i = 0; i < 3; i++) begin
      r = rnd();
      ch = r[2:0];
      base <= 12'h400 + 12'(r[12:3]);
      expc = 12'h400 + 12'(r[12:3]) + 12'(r[2:0]);
      apb(1'b1, acgc_pkg::ADDR_CHAN, 32'(ch));
      apb(1'b1, acgc_pkg::ADDR_CTRL, 32'h1 << acgc_pkg::CTRL_START_BIT);
      k = 0;
      while (sw !== 1'b1 && k < 100) begin
        @(posedge clk_sys);
        k++;
      end
      chk("mux", 32'(ch), 32'(mux));
      k = 0;
      while (sw === 1'b1 && k < 100) begin
        @(posedge clk_sys);
        k++;
      end
      chk("acq_len", 32'h1, 32'(k >= 40 && k <= 42));
      poll(acgc_pkg::ADDR_CTRL, acgc_pkg::CTRL_START_BIT, 1'b0, 60);
      repeat (5) @(posedge clk_sys);
      apb(1'b0, acgc_pkg::ADDR_RESULT, 32'h0);
      chk("result", 32'({ch, 4'h0, expc}), rd);
    end
    $display("test manual done");
    // High then low threshold crossing on the last channel
    for (k = 0; k < 2; k++) begin
      apb(1'b1, k ? acgc_pkg::ADDR_LO_THR : acgc_pkg::ADDR_HI_THR,
        32'(k ? expc + 12'h1 : expc - 12'h1));
      conv(32'h1 << acgc_pkg::CTRL_START_BIT);
      apb(1'b0, acgc_pkg::ADDR_EVENT, 32'h0);
      chk("event", 32'h1 << ch, rd);
      chk("alert_on", 32'h1, 32'(alert));
      apb(1'b1, acgc_pkg::ADDR_HI_THR, 32'hFFF);
      apb(1'b1, acgc_pkg::ADDR_LO_THR, 32'h0);
      apb(1'b1, acgc_pkg::ADDR_EVENT, 32'hFF);
      repeat (3) @(posedge clk_sys);
      chk("alert_off", 32'h0, 32'(alert));
    end
    conv((32'h1 << acgc_pkg::CTRL_AVG_BIT) | (32'h1 << acgc_pkg::CTRL_START_BIT));
    apb(1'b0, acgc_pkg::ADDR_AVG, 32'h0);
    chk("avg", 32'({expc, 4'h0}), rd);
    $display("test threshold_avg done");
    // Scan must visit analog channels only
    r = rnd();
    pm = r[7:0] & 8'h7F;
    apb(1'b1, acgc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, acgc_pkg::ADDR_PIN_MODE, 32'(pm));
    apb(1'b1, acgc_pkg::ADDR_CTRL, 32'h1 << acgc_pkg::CTRL_AUTO_BIT);
    k = 0;
    prev = 1'b0;
    repeat (1000) begin
      @(posedge clk_sys);
      if (sw === 1'b1 && prev === 1'b0) begin
        k++;
        chk("scan_ch", 32'h0, 32'(pm[mux]));
      end
      prev = sw;
    end
    chk("scans", 32'h1, 32'(k >= 2));
    apb(1'b1, acgc_pkg::ADDR_CTRL, 32'h0);
    $display("test auto done");
    apb(1'b1, acgc_pkg::ADDR_PIN_MODE, 32'hFF);
    apb(1'b1, acgc_pkg::ADDR_CTRL, 32'h1 << acgc_pkg::CTRL_RST_BIT);
    apb(1'b0, acgc_pkg::ADDR_CTRL, 32'h0);
    chk("reset_bit", 32'h1, 32'(rd[acgc_pkg::CTRL_RST_BIT]));
    poll(acgc_pkg::ADDR_CTRL, acgc_pkg::CTRL_RST_BIT, 1'b0, 10);
    chk("ready", 32'h1, 32'(rd[acgc_pkg::CTRL_READY_BIT]));
    chk("analog_after", 32'hFF, 32'(aen));
    apb(1'b0, acgc_pkg::ADDR_PIN_MODE, 32'h0);
    chk("pin_mode_after", 32'h0, rd);
    $display("test soft_reset done");
    finish_test();
  end
endmodule
